/* common/flash_port_pkg.sv */
// shared constants and types for the user flash serial port, both ends
package flash_port_pkg;

  // ==========================================================
  // array shape
  localparam int ADDR_W = 9; // word address width
  localparam int DATA_W = 16; // word width
  localparam int WORDS = 512; // total words
  localparam int SECTOR_WORDS = 256; // words per sector
  localparam int SECTOR_BIT = 8; // address bit that picks the sector
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000; // address register after reset
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000; // data register after reset
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff; // value of an erased word

  // ==========================================================
  // timing
  localparam int CORE_CLK_HZ = 20_000_000; // core_clk rate
  localparam int REG_CLK_MAX_HZ = 10_000_000; // fastest register clock allowed
  // least half period of a register clock in core cycles, rounded up
  localparam int REG_CLK_MIN_HALF = (CORE_CLK_HZ + 2 * REG_CLK_MAX_HZ - 1) / (2 * REG_CLK_MAX_HZ);
  localparam int REG_CLK_HALF_DEFAULT = 2; // host half period, leaves a sampling margin
  localparam int OSC_HALF_CYCLES = 2; // divided clock is core rate over four
  localparam int PROGRAM_TIME_US = 100; // word program duration
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * (CORE_CLK_HZ / 1_000_000);
  localparam int ERASE_TIME_US = 1000; // sector erase duration
  localparam int ERASE_CYCLES = ERASE_TIME_US * (CORE_CLK_HZ / 1_000_000);
  localparam int LIVE_WARN_MS = 500; // warning window before reconfiguration
  localparam int LIVE_WARN_CYCLES = LIVE_WARN_MS * (CORE_CLK_HZ / 1000);
  localparam int RECONFIG_TIME_MS = 10; // background reconfiguration duration
  localparam int RECONFIG_CYCLES = RECONFIG_TIME_MS * (CORE_CLK_HZ / 1000);

  // ==========================================================
  // host commands
  typedef enum logic [1:0] {
    OP_READ,
    OP_READ_NEXT,
    OP_WRITE,
    OP_ERASE
  } flash_op_t;

endpackage

/* common/flash_port_if.sv */
// pin bundle between the flash serial port and its user-side host logic
`timescale 1ns/100ps
interface flash_port_if;
  logic data_serial_in; // host to device, serial data
  logic data_serial_out; // device to host, data register MSB
  logic data_reg_clock; // host made data register clock
  logic data_shift_select; // high shift, low parallel load
  logic address_serial_in; // host to device, serial address
  logic address_reg_clock; // host made address register clock
  logic address_shift_select; // high shift, low increment
  logic program_trigger; // rising edge starts a program
  logic erase_trigger; // rising edge starts a sector erase
  logic busy; // program or erase running
  logic clock_source_enable; // oscillator on
  logic divided_clock; // oscillator output
  logic live_update_busy; // background reconfiguration pending or running

  // ==========================================================
  modport device (
    input data_serial_in, data_reg_clock, data_shift_select,
    input address_serial_in, address_reg_clock, address_shift_select,
    input program_trigger, erase_trigger, clock_source_enable,
    output data_serial_out, busy, divided_clock, live_update_busy
  );

  modport host (
    output data_serial_in, data_reg_clock, data_shift_select,
    output address_serial_in, address_reg_clock, address_shift_select,
    output program_trigger, erase_trigger, clock_source_enable,
    input data_serial_out, busy, divided_clock, live_update_busy
  );
endinterface // flash_port_if

/* design/clock_divider.sv */
// gated divider that models the flash oscillator output
`timescale 1ns/100ps
module clock_divider #(
  parameter int HALF_CYCLES = 2 // core cycles per output half period
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic enable,
  output logic clock_out
);

  // ==========================================================
  // checks
  if (HALF_CYCLES < 1) begin : g_bad_half
    $error("clock_divider: HALF_CYCLES must be at least 1");
  end

  localparam int CW = $clog2(HALF_CYCLES + 1); // counter width

  typedef struct packed {
    logic [CW-1:0] cnt; // cycles into the half period
    logic level; // output level
  } div_state_t;

  div_state_t s_q; // registered state
  div_state_t s_d; // next state

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      // stopped oscillator parks high
      s_d.cnt = '0;
      s_d.level = 1'b1;
    end else if (s_q.cnt == CW'(HALF_CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.level = ~s_q.level;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{cnt: '0, level: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign clock_out = s_q.level;

endmodule // clock_divider

/* design/flash_port_device.sv */
// device end: address and data registers, flash array, program/erase control
`timescale 1ns/100ps
module flash_port_device #(
  parameter int PROGRAM_LEN = flash_port_pkg::PROGRAM_CYCLES, // program duration, cycles
  parameter int ERASE_LEN = flash_port_pkg::ERASE_CYCLES, // erase duration, cycles
  parameter int LIVE_WARN_LEN = flash_port_pkg::LIVE_WARN_CYCLES, // warning window, cycles
  parameter int RECONFIG_LEN = flash_port_pkg::RECONFIG_CYCLES // reconfiguration, cycles
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic live_update_request,
  flash_port_if.device port
);
  import flash_port_pkg::*;

  // ==========================================================
  // checks
  if (PROGRAM_LEN < 1) begin : g_bad_program
    $error("flash_port_device: PROGRAM_LEN must be at least 1");
  end
  // erase walks one word per cycle, so it needs a whole sector of cycles
  if (ERASE_LEN < SECTOR_WORDS) begin : g_bad_erase
    $error("flash_port_device: ERASE_LEN must cover one sector");
  end
  if (LIVE_WARN_LEN < 1 || RECONFIG_LEN < 1) begin : g_bad_live
    $error("flash_port_device: live update lengths must be at least 1");
  end

  // ==========================================================
  // state layout
  localparam int OP_MAX = (PROGRAM_LEN > ERASE_LEN) ? PROGRAM_LEN : ERASE_LEN;
  localparam int OTW = $clog2(OP_MAX + 1); // operation timer width
  localparam int LV_MAX = (LIVE_WARN_LEN > RECONFIG_LEN) ? LIVE_WARN_LEN : RECONFIG_LEN;
  localparam int LTW = $clog2(LV_MAX + 1); // live update timer width

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROGRAM,
    ST_ERASE
  } op_state_t;

  typedef enum logic [1:0] {
    LV_RUN,
    LV_WARN,
    LV_RECONFIG
  } live_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr; // address register
    logic [DATA_W-1:0] data; // data register
    logic dclk_prev; // data clock last cycle
    logic aclk_prev; // address clock last cycle
    logic prog_prev; // program trigger last cycle
    logic erase_prev; // erase trigger last cycle
    op_state_t op; // program/erase sequencer
    logic [OTW-1:0] op_timer; // cycles into the operation
    logic busy; // busy output
    live_state_t live; // background update phase
    logic [LTW-1:0] live_timer; // cycles into the phase
    logic live_busy; // live update busy output
  } dev_state_t;

  localparam dev_state_t RESET_STATE = '{
    addr: ADDR_RESET,
    data: DATA_RESET,
    op: ST_IDLE,
    live: LV_RUN,
    default: '0
  };

  dev_state_t s_q; // registered state
  dev_state_t s_d; // next state

  // ==========================================================
  // flash array
  // blank part powers up erased; no reset, contents must survive it
  logic [DATA_W-1:0] mem [WORDS] = '{default: ERASED_WORD}; // non-volatile words
  logic mem_we; // write strobe
  logic [ADDR_W-1:0] mem_waddr; // write address
  logic [DATA_W-1:0] mem_wdata; // write data

  // single write port shared by program and erase
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ==========================================================
  // edge detection on host driven pins
  logic d_rise; // data clock rising
  logic a_rise; // address clock rising
  logic p_rise; // program trigger rising
  logic e_rise; // erase trigger rising
  logic regs_open; // registers may move

  // pins are synchronous to core_clk, so one previous sample is enough
  assign d_rise = port.data_reg_clock & ~s_q.dclk_prev;
  assign a_rise = port.address_reg_clock & ~s_q.aclk_prev;
  assign p_rise = port.program_trigger & ~s_q.prog_prev;
  assign e_rise = port.erase_trigger & ~s_q.erase_prev;
  // frozen while busy so the target word cannot move mid operation
  assign regs_open = (s_q.op == ST_IDLE) && (s_q.live != LV_RECONFIG);

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_waddr = s_q.addr;
    mem_wdata = s_q.data;
    s_d.dclk_prev = port.data_reg_clock;
    s_d.aclk_prev = port.address_reg_clock;
    s_d.prog_prev = port.program_trigger;
    s_d.erase_prev = port.erase_trigger;

    // address register
    if (regs_open && a_rise) begin
      if (port.address_shift_select) begin
        // serial bit enters at LSB, first bit ends up as MSB
        s_d.addr = {s_q.addr[ADDR_W-2:0], port.address_serial_in};
      end else begin
        // natural 9-bit overflow gives the wrap to zero
        s_d.addr = s_q.addr + 1'b1;
      end
    end

    // data register
    if (regs_open && d_rise) begin
      if (port.data_shift_select) begin
        s_d.data = {s_q.data[DATA_W-2:0], port.data_serial_in};
      end else begin
        s_d.data = mem[s_q.addr];
      end
    end

    // program/erase sequencer
    unique case (s_q.op)
      ST_IDLE: begin
        // edges that arrive while busy were not seen here and are dropped
        if (s_q.live != LV_RECONFIG) begin
          if (p_rise) begin
            s_d.op = ST_PROGRAM;
            s_d.op_timer = '0;
          end else if (e_rise) begin
            s_d.op = ST_ERASE;
            s_d.op_timer = '0;
          end
        end
      end
      ST_PROGRAM: begin
        s_d.op_timer = s_q.op_timer + 1'b1;
        // word is committed at the end of the program time
        if (s_q.op_timer == OTW'(PROGRAM_LEN - 1)) begin
          mem_we = 1'b1;
          s_d.op = ST_IDLE;
        end
      end
      ST_ERASE: begin
        s_d.op_timer = s_q.op_timer + 1'b1;
        // one word per cycle across the sector picked by the address MSB
        if (s_q.op_timer < OTW'(SECTOR_WORDS)) begin
          mem_we = 1'b1;
          mem_waddr = {s_q.addr[SECTOR_BIT], s_q.op_timer[SECTOR_BIT-1:0]};
          mem_wdata = ERASED_WORD;
        end
        if (s_q.op_timer == OTW'(ERASE_LEN - 1)) begin
          s_d.op = ST_IDLE;
        end
      end
      default: begin
        s_d.op = ST_IDLE;
      end
    endcase
    s_d.busy = (s_d.op != ST_IDLE);

    // background update
    unique case (s_q.live)
      LV_RUN: begin
        if (live_update_request) begin
          s_d.live = LV_WARN;
          s_d.live_timer = '0;
        end
      end
      LV_WARN: begin
        if (s_q.live_timer != LTW'(LIVE_WARN_LEN - 1)) begin
          s_d.live_timer = s_q.live_timer + 1'b1;
        end else if (s_d.op == ST_IDLE) begin
          // a late program or erase is let finish before the registers go
          s_d.live = LV_RECONFIG;
          s_d.live_timer = '0;
          s_d.addr = ADDR_RESET;
          s_d.data = DATA_RESET;
        end
      end
      LV_RECONFIG: begin
        s_d.live_timer = s_q.live_timer + 1'b1;
        if (s_q.live_timer == LTW'(RECONFIG_LEN - 1)) begin
          s_d.live = LV_RUN;
        end
      end
      default: begin
        s_d.live = LV_RUN;
      end
    endcase
    s_d.live_busy = (s_d.live != LV_RUN);
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  // the register MSB is the serial output, after a shift or a load
  assign port.data_serial_out = s_q.data[DATA_W-1];
  assign port.busy = s_q.busy;
  assign port.live_update_busy = s_q.live_busy;

  // oscillator model, core rate over four
  clock_divider #(
    .HALF_CYCLES(OSC_HALF_CYCLES)
  ) clock_divider_i (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(port.clock_source_enable),
    .clock_out(port.divided_clock)
  );

endmodule // flash_port_device

/* design/flash_port_host.sv */
// host end: turns word commands into serial pin sequences
`timescale 1ns/100ps
module flash_port_host #(
  parameter int REG_CLK_HALF = flash_port_pkg::REG_CLK_HALF_DEFAULT // core cycles per half clock
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire flash_port_pkg::flash_op_t cmd_op,
  input wire logic [flash_port_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [flash_port_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic osc_request,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [flash_port_pkg::DATA_W-1:0] rsp_rdata,
  flash_port_if.host port
);
  import flash_port_pkg::*;

  // ==========================================================
  // checks: two cycles per half keep the sample after the device update
  if (REG_CLK_HALF < REG_CLK_MIN_HALF || REG_CLK_HALF < 2) begin : g_bad_half
    $error("flash_port_host: REG_CLK_HALF too small");
  end

  localparam int CW = $clog2(2 * REG_CLK_HALF + 1); // slot counter width

  typedef enum logic [2:0] {
    H_IDLE,
    H_ADDR_SHIFT,
    H_ADDR_INC,
    H_DATA_SHIFT,
    H_LOAD,
    H_READ_SHIFT,
    H_TRIGGER,
    H_WAIT
  } host_state_t;

  typedef struct packed {
    host_state_t state; // sequence step
    flash_op_t op; // command in progress
    logic [DATA_W-1:0] shreg; // bits still to send, MSB first
    logic [DATA_W-1:0] rdata; // bits collected
    logic [4:0] bits; // slots left in this step
    logic [CW-1:0] cnt; // cycles into the slot
    logic aclk; // address clock pin
    logic dclk; // data clock pin
    logic ashift; // address shift select pin
    logic dshift; // data shift select pin
    logic prog; // program trigger pin
    logic erase; // erase trigger pin
    logic osc_en; // oscillator request for program/erase
    logic rsp_valid; // answer strobe
    logic rsp_error; // command cut short by a live update
    logic reload; // device address no longer trusted
    logic done; // answer due next cycle
  } host_reg_t;

  host_reg_t s_q; // registered state
  host_reg_t s_d; // next state
  logic slot_end; // last cycle of a clock slot
  logic clk_hi; // clock phase of the next slot cycle
  logic in_slot; // a clocked step is running
  logic [DATA_W-1:0] cmd_wdata_q; // write word kept from acceptance

  assign slot_end = (s_q.cnt == CW'(2 * REG_CLK_HALF - 1));
  assign in_slot = (s_q.state inside {H_ADDR_SHIFT, H_ADDR_INC, H_DATA_SHIFT, H_LOAD,
                                      H_READ_SHIFT});
  // no new work while the device is busy or a live update is pending
  assign cmd_ready = (s_q.state == H_IDLE) && !s_q.done && !port.busy
                     && !port.live_update_busy;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    s_d.done = 1'b0;
    if (in_slot) begin
      s_d.cnt = slot_end ? '0 : s_q.cnt + 1'b1;
      if (slot_end) begin
        s_d.bits = s_q.bits - 1'b1;
      end
    end
    if (port.live_update_busy) begin
      s_d.reload = 1'b1;
    end

    unique case (s_q.state)
      H_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          s_d.op = cmd_op;
          s_d.cnt = '0;
          s_d.rsp_error = 1'b0;
          if (cmd_op == OP_READ_NEXT && !s_q.reload) begin
            s_d.state = H_ADDR_INC;
            s_d.ashift = 1'b0;
            s_d.bits = 5'd1;
          end else begin
            s_d.state = H_ADDR_SHIFT;
            s_d.ashift = 1'b1;
            s_d.shreg = {cmd_addr, 7'h00};
            s_d.bits = 5'(ADDR_W);
            s_d.reload = 1'b0;
          end
        end
      end
      H_ADDR_SHIFT, H_DATA_SHIFT: begin
        if (slot_end) begin
          s_d.shreg = {s_q.shreg[DATA_W-2:0], 1'b0};
          if (s_q.bits == 5'd1) begin
            if (s_q.state == H_ADDR_SHIFT && s_q.op == OP_WRITE) begin
              s_d.state = H_DATA_SHIFT;
              s_d.dshift = 1'b1;
              s_d.shreg = cmd_wdata_q;
              s_d.bits = 5'(DATA_W);
            end else if (s_q.op == OP_WRITE || s_q.op == OP_ERASE) begin
              s_d.state = H_TRIGGER;
              s_d.prog = (s_q.op == OP_WRITE);
              s_d.erase = (s_q.op == OP_ERASE);
              s_d.osc_en = 1'b1;
            end else begin
              s_d.state = H_LOAD;
              s_d.dshift = 1'b0;
              s_d.bits = 5'd1;
            end
          end
        end
      end
      H_ADDR_INC: begin
        if (slot_end) begin
          s_d.state = H_LOAD;
          s_d.dshift = 1'b0;
          s_d.bits = 5'd1;
        end
      end
      H_LOAD, H_READ_SHIFT: begin
        // sampled at slot end, the first cycle that shows the moved register when REG_CLK_HALF is 2
        if (slot_end) begin
          s_d.rdata = {s_q.rdata[DATA_W-2:0], port.data_serial_out};
          if (s_q.state == H_LOAD) begin
            s_d.state = H_READ_SHIFT;
            s_d.dshift = 1'b1;
            s_d.bits = 5'(DATA_W - 1);
          end else if (s_q.bits == 5'd1) begin
            s_d.state = H_IDLE;
            s_d.done = 1'b1;
          end
        end
      end
      H_TRIGGER: begin
        if (port.busy) begin
          s_d.state = H_WAIT;
          s_d.prog = 1'b0;
          s_d.erase = 1'b0;
        end
      end
      H_WAIT: begin
        if (!port.busy) begin
          s_d.state = H_IDLE;
          s_d.osc_en = 1'b0;
          s_d.done = 1'b1;
        end
      end
      default: begin
        s_d.state = H_IDLE;
      end
    endcase

    // a live update cuts any running step short except H_WAIT
    if (s_q.state != H_IDLE && s_q.state != H_WAIT && port.live_update_busy) begin
      s_d.state = H_IDLE;
      s_d.prog = 1'b0;
      s_d.erase = 1'b0;
      s_d.osc_en = 1'b0;
      s_d.rsp_error = 1'b1;
      s_d.done = 1'b1;
    end
    if (s_q.done) begin
      s_d.rsp_valid = 1'b1;
    end

    // each slot is half low then half high: rate stays within the limit
    clk_hi = (s_d.cnt >= CW'(REG_CLK_HALF));
    s_d.aclk = clk_hi && (s_d.state inside {H_ADDR_SHIFT, H_ADDR_INC});
    s_d.dclk = clk_hi && (s_d.state inside {H_DATA_SHIFT, H_LOAD, H_READ_SHIFT});
  end

  // write word kept from acceptance, the command port may move on
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_wdata_q <= DATA_RESET;
    end else if (cmd_valid && cmd_ready) begin
      cmd_wdata_q <= cmd_wdata;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{state: H_IDLE, op: OP_READ, reload: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign port.address_serial_in = s_q.shreg[DATA_W-1];
  assign port.data_serial_in = s_q.shreg[DATA_W-1];
  assign port.address_reg_clock = s_q.aclk;
  assign port.data_reg_clock = s_q.dclk;
  assign port.address_shift_select = s_q.ashift;
  assign port.data_shift_select = s_q.dshift;
  assign port.program_trigger = s_q.prog;
  assign port.erase_trigger = s_q.erase;
  assign port.clock_source_enable = s_q.osc_en | osc_request;
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_error = s_q.rsp_error;
  assign rsp_rdata = s_q.rdata;

endmodule // flash_port_host

/* verif/flash_port_assertions.sv */
// pin-level checks on the link between the two flash port ends
`timescale 1ns/100ps
module flash_port_assertions #(parameter int PL = 4, parameter int EL = 300) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic program_trigger,
  input wire logic erase_trigger,
  input wire logic busy,
  input wire logic data_reg_clock,
  input wire logic address_reg_clock,
  input wire logic data_serial_out,
  input wire logic clock_source_enable,
  input wire logic divided_clock,
  input wire logic live_update_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  int busy_n_q; // busy cycles so far, length is checked at the fall
  // ==========================================================
  // busy run counter, a 20000 cycle erase is too long to unroll
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n) busy_n_q <= 0;
    else busy_n_q <= busy ? busy_n_q + 1 : 0;
  // ==========================================================
  // properties
  sequence s_idle_trig;
    ($rose(program_trigger) || $rose(erase_trigger)) && !busy && !live_update_busy;
  endsequence
  sequence s_live; live_update_busy[*2]; endsequence
  property p_start; s_idle_trig |=> busy; endproperty
  property p_len; $fell(busy) |-> busy_n_q == PL || busy_n_q == EL; endproperty
  property p_cause; $rose(busy) |-> $past(program_trigger) || $past(erase_trigger); endproperty
  property p_hold; busy[*2] |-> $stable(data_serial_out); endproperty
  property p_noclk; busy |-> $stable(data_reg_clock) && $stable(address_reg_clock); endproperty
  property p_drate; $rose(data_reg_clock) |=> data_reg_clock; endproperty
  property p_arate; $rose(address_reg_clock) |=> address_reg_clock; endproperty
  property p_quiet;
    s_live |=> !$rose(program_trigger) && !$rose(erase_trigger) && !$rose(data_reg_clock)
      && !$rose(address_reg_clock);
  endproperty
  property p_off; !clock_source_enable[*3] |=> divided_clock; endproperty
  property p_on;
    clock_source_enable[*8] |-> !(divided_clock && $past(divided_clock) && $past(divided_clock, 2));
  endproperty
  a_start: assert property (p_start) else $error("no busy after trigger");
  a_len: assert property (p_len) else $error("busy length wrong");
  a_cause: assert property (p_cause) else $error("busy without trigger");
  a_hold: assert property (p_hold) else $error("data moved while busy");
  a_noclk: assert property (p_noclk) else $error("clocked while busy");
  a_drate: assert property (p_drate) else $error("data clock too fast");
  a_arate: assert property (p_arate) else $error("address clock too fast");
  a_quiet: assert property (p_quiet) else $error("access during live update");
  a_off: assert property (p_off) else $error("divided clock not high");
  a_on: assert property (p_on) else $error("divided clock stuck");
endmodule // flash_port_assertions

/* verif/user_flash_serial_port_bench.sv */
// self-checking bench: host and device ends joined over the pin bundle
`timescale 1ns/100ps
module user_flash_serial_port_bench;
  import flash_port_pkg::*;
  localparam int PL_T = 4; // short program time
  localparam int EL_T = 300; // short erase time, above one sector
  logic core_clk = 0, reset_n = 0, cmd_valid = 0, osc_request = 0, lu_req = 0, osc_bit;
  flash_op_t cmd_op = OP_READ;
  logic [ADDR_W-1:0] cmd_addr = 9'h000;
  logic [DATA_W-1:0] cmd_wdata = 16'h0000;
  logic cmd_ready, rsp_valid, rsp_error;
  logic [DATA_W-1:0] rsp_rdata;
  int num_errors = 0, total_checks = 0;
  flash_port_if port_if ();
  always #25 core_clk = ~core_clk;
  flash_port_device #(.PROGRAM_LEN(PL_T), .ERASE_LEN(EL_T), .LIVE_WARN_LEN(20),
    .RECONFIG_LEN(10)) flash_port_device_i (.core_clk(core_clk), .reset_n(reset_n),
    .live_update_request(lu_req), .port(port_if));
  flash_port_host flash_port_host_i (.core_clk(core_clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .osc_request(osc_request), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_rdata(rsp_rdata), .port(port_if));
  flash_port_assertions #(.PL(PL_T), .EL(EL_T)) flash_port_assertions_i (.core_clk(core_clk),
    .reset_n(reset_n), .program_trigger(port_if.program_trigger),
    .erase_trigger(port_if.erase_trigger), .busy(port_if.busy),
    .data_reg_clock(port_if.data_reg_clock), .address_reg_clock(port_if.address_reg_clock),
    .data_serial_out(port_if.data_serial_out),
    .clock_source_enable(port_if.clock_source_enable),
    .divided_clock(port_if.divided_clock), .live_update_busy(port_if.live_update_busy));
  // ==========================================================
  // compare and count
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one command; v is write data or expected read word, lu_at>0 aborts it
  task automatic run_cmd(input flash_op_t op, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] v, input int lu_at);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = v;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    if (lu_at > 0) begin
      repeat (lu_at) @(negedge core_clk);
      lu_req = 1'b1;
      @(negedge core_clk);
      lu_req = 1'b0;
    end
    while (rsp_valid !== 1'b1 && n < 10000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (rsp_valid !== 1'b1) chk(rsp_valid, 1'b1); // limit ran out
    if (lu_at == 0 && (op == OP_READ || op == OP_READ_NEXT)) chk(rsp_rdata, v);
    chk(rsp_error, lu_at > 0);
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // watchdog, the whole run needs about 1500 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    reset_n = 1'b1;
    chk(port_if.busy, 1'b0);
    chk(port_if.divided_clock, 1'b1);
    run_cmd(OP_READ, 9'h005, 16'hffff, 0);
    run_cmd(OP_WRITE, 9'h005, 16'ha5c3, 0);
    run_cmd(OP_WRITE, 9'h000, 16'h0f0f, 0);
    run_cmd(OP_WRITE, 9'h1ff, 16'h1234, 0);
    run_cmd(OP_READ, 9'h005, 16'ha5c3, 0);
    $display("test write_read done");
    run_cmd(OP_READ, 9'h1ff, 16'h1234, 0);
    run_cmd(OP_READ_NEXT, 9'h1ff, 16'h0f0f, 0);
    run_cmd(OP_READ_NEXT, 9'h1ff, 16'hffff, 0);
    $display("test stream done");
    run_cmd(OP_ERASE, 9'h1ff, 16'h0000, 0);
    run_cmd(OP_READ, 9'h1ff, 16'hffff, 0);
    run_cmd(OP_READ, 9'h000, 16'h0f0f, 0);
    $display("test erase done");
    run_cmd(OP_READ, 9'h005, 16'h0000, 10);
    run_cmd(OP_READ_NEXT, 9'h005, 16'ha5c3, 0);
    $display("test live_update done");
    osc_request = 1'b1;
    repeat (8) @(negedge core_clk);
    osc_bit = port_if.divided_clock;
    repeat (2) @(negedge core_clk);
    chk(port_if.divided_clock, !osc_bit);
    osc_request = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(port_if.divided_clock, 1'b1);
    $display("test oscillator done");
    print_verdict();
  end
endmodule // user_flash_serial_port_bench
